// *** common/ppac_pkg.sv ***
// Purpose: constants and types for the pwm prescale, alignment and concatenation control block
// Assumes: 8-bit registers on a plain address/strobe port
// Notes: register offsets are local choices
package ppac_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int NUM_CH = 8;
	localparam int PRE_W = 7;
	localparam logic [ADDR_W-1:0] OFS_PRESCALE = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_CENTER = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_SCALE_A = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_SCALE_B = 4'h4;
	localparam logic [DATA_W-1:0] RST_REG = 8'h00;
	localparam logic [DATA_W-1:0] PRESCALE_MASK = 8'h77;
	localparam logic [DATA_W-1:0] CONTROL_MASK = 8'hfc;
	localparam int CLOCK_A_PRESCALE_SEL_LSB = 0;
	localparam int CLOCK_B_PRESCALE_SEL_LSB = 4;
	localparam int SEL_W = 3;
	localparam int CTL_JOIN_HIGH = 7;
	localparam int CTL_JOIN_UMID = 6;
	localparam int CTL_JOIN_LMID = 5;
	localparam int CTL_JOIN_LOW = 4;
	localparam int CTL_DOZE = 3;
	localparam int CTL_DEBUG = 2;
	localparam logic [DATA_W-1:0] SCALE_ONE = 8'h01;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} ppac_bus_s;

	typedef struct packed {
		logic clk_a_en;
		logic clk_b_en;
		logic scaled_a_en;
		logic scaled_b_en;
	} ppac_tick_s;
endpackage : ppac_pkg

// *** hw/ppac_ctrl.sv ***
// Purpose: prescaler, scaled clocks, alignment and concatenation control for an eight-channel pwm
// Assumes: all inputs synchronous to ref_clk; rst synchronous active high
// Notes: clocks are delivered as one-cycle enable pulses on ref_clk
// Contract
// - clock b tick is bus clock divided by two to the field in bits 6..4
// - clock a tick is bus clock divided by two to the field in bits 2..0
// - prescale changes may glitch one pulse; no guard needed
// - alignment bit n picks left (0) or center (1) for channel n
// - when a pair joins, the even channel alignment bit is ignored
// - control bit 7 joins channels 6 and 7; output only on pin 7
// - control bit 6 joins channels 4 and 5; pin 4 disabled
// - control bit 5 joins channels 2 and 3; pin 2 disabled
// - control bit 4 joins channels 0 and 1; pin 0 disabled
// - control bit 3 stops prescaler input while in doze mode
// - control bit 2 stops prescaler input while breakpoint is asserted
// - channel select bit picks unscaled (0) or scaled clock of its group
// - scaled clock is clock divided by twice scale value, zero means 256; write reloads
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module ppac_ctrl (
	input wire logic ref_clk, // bus clock, 50 MHz
	input wire logic rst, // synchronous reset, active high
	input wire logic clk_en, // freezes all state while low
	input wire ppac_pkg::ppac_bus_s bus, // register port request
	output logic [ppac_pkg::DATA_W-1:0] rdata, // read data, cycle after read strobe
	input wire logic doze_mode, // core in doze mode
	input wire logic breakpoint_signal, // core in debug mode
	input wire logic [ppac_pkg::NUM_CH-1:0] channel_clock_select, // per-channel scaled select
	input wire logic [ppac_pkg::NUM_CH-1:0] channel_out_raw, // per-channel waveform from counters
	output ppac_pkg::ppac_tick_s ticks, // group clock enables
	output logic [ppac_pkg::NUM_CH-1:0] channel_tick, // clock enable per channel
	output logic [ppac_pkg::NUM_CH-1:0] center_align_bit, // effective alignment per channel
	output logic [ppac_pkg::NUM_CH/2-1:0] join_pair, // concatenation flags, pair 0..3
	output logic [ppac_pkg::NUM_CH-1:0] channel_output_pin // pin values after concatenation
);
	logic [ppac_pkg::DATA_W-1:0] prescale_r, prescale_nxt;
	logic [ppac_pkg::DATA_W-1:0] center_r, center_nxt;
	logic [ppac_pkg::DATA_W-1:0] control_r, control_nxt;
	logic [ppac_pkg::DATA_W-1:0] scale_a_value_r, scale_a_value_nxt;
	logic [ppac_pkg::DATA_W-1:0] scale_b_value_r, scale_b_value_nxt;
	logic [ppac_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
	logic [ppac_pkg::PRE_W-1:0] pre_cnt_r, pre_cnt_nxt;
	logic [ppac_pkg::DATA_W-1:0] sa_cnt_r, sa_cnt_nxt;
	logic [ppac_pkg::DATA_W-1:0] sb_cnt_r, sb_cnt_nxt;
	logic sa_half_r, sa_half_nxt;
	logic sb_half_r, sb_half_nxt;
	logic [ppac_pkg::SEL_W-1:0] clock_a_prescale_sel;
	logic [ppac_pkg::SEL_W-1:0] clock_b_prescale_sel;
	logic pre_run;
	logic tick_a, tick_b, scaled_clock_a, scaled_clock_b;
	logic wr_sa, wr_sb;
	logic [ppac_pkg::PRE_W:0] pre_ext;

	assign clock_a_prescale_sel = prescale_r[ppac_pkg::CLOCK_A_PRESCALE_SEL_LSB +: ppac_pkg::SEL_W];
	assign clock_b_prescale_sel = prescale_r[ppac_pkg::CLOCK_B_PRESCALE_SEL_LSB +: ppac_pkg::SEL_W];
	assign join_pair = {control_r[ppac_pkg::CTL_JOIN_HIGH], control_r[ppac_pkg::CTL_JOIN_UMID],
		control_r[ppac_pkg::CTL_JOIN_LMID], control_r[ppac_pkg::CTL_JOIN_LOW]};
	assign wr_sa = bus.wr && bus.addr == ppac_pkg::OFS_SCALE_A;
	assign wr_sb = bus.wr && bus.addr == ppac_pkg::OFS_SCALE_B;

	// register file
	always_comb begin
		prescale_nxt = prescale_r;
		center_nxt = center_r;
		control_nxt = control_r;
		scale_a_value_nxt = scale_a_value_r;
		scale_b_value_nxt = scale_b_value_r;
		rdata_nxt = ppac_pkg::RST_REG;
		if (bus.wr) begin
			unique case (bus.addr)
				ppac_pkg::OFS_PRESCALE: prescale_nxt = bus.wdata & ppac_pkg::PRESCALE_MASK;
				ppac_pkg::OFS_CENTER: center_nxt = bus.wdata;
				ppac_pkg::OFS_CONTROL: control_nxt = bus.wdata & ppac_pkg::CONTROL_MASK;
				ppac_pkg::OFS_SCALE_A: scale_a_value_nxt = bus.wdata;
				ppac_pkg::OFS_SCALE_B: scale_b_value_nxt = bus.wdata;
				default: ;
			endcase
		end
		if (bus.rd) begin
			unique case (bus.addr)
				ppac_pkg::OFS_PRESCALE: rdata_nxt = prescale_r;
				ppac_pkg::OFS_CENTER: rdata_nxt = center_r;
				ppac_pkg::OFS_CONTROL: rdata_nxt = control_r;
				ppac_pkg::OFS_SCALE_A: rdata_nxt = scale_a_value_r;
				ppac_pkg::OFS_SCALE_B: rdata_nxt = scale_b_value_r;
				default: rdata_nxt = ppac_pkg::RST_REG;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prescale_r <= ppac_pkg::RST_REG;
			center_r <= ppac_pkg::RST_REG;
			control_r <= ppac_pkg::RST_REG;
			scale_a_value_r <= ppac_pkg::RST_REG;
			scale_b_value_r <= ppac_pkg::RST_REG;
			rdata_r <= ppac_pkg::RST_REG;
		end else if (clk_en) begin
			prescale_r <= prescale_nxt;
			center_r <= center_nxt;
			control_r <= control_nxt;
			scale_a_value_r <= scale_a_value_nxt;
			scale_b_value_r <= scale_b_value_nxt;
			rdata_r <= rdata_nxt;
		end
	end
	assign rdata = rdata_r;

	// prescaler input gating
	assign pre_run = !(control_r[ppac_pkg::CTL_DOZE] && doze_mode)
		&& !(control_r[ppac_pkg::CTL_DEBUG] && breakpoint_signal);

	// free-running counter; tick when the low sel bits are all ones, the cycle before they wrap to zero
	always_comb begin
		pre_cnt_nxt = pre_cnt_r;
		if (pre_run) begin
			pre_cnt_nxt = pre_cnt_r + 1'b1;
		end
	end
	assign pre_ext = {1'b0, pre_cnt_r};

	function automatic logic pre_tick(input logic [ppac_pkg::PRE_W:0] cnt, input logic [ppac_pkg::SEL_W-1:0] sel);
		logic [ppac_pkg::PRE_W:0] mask;
		mask = (({{ppac_pkg::PRE_W{1'b0}}, 1'b1}) << sel) - 1'b1;
		pre_tick = (cnt & mask) == mask;
	endfunction : pre_tick

	// selection change may cut one period short, accepted
	assign tick_a = pre_run && pre_tick(pre_ext, clock_a_prescale_sel);
	assign tick_b = pre_run && pre_tick(pre_ext, clock_b_prescale_sel);

	// scaled clocks: count scale ticks, toggle half, pulse every second wrap
	always_comb begin
		sa_cnt_nxt = sa_cnt_r;
		sa_half_nxt = sa_half_r;
		sb_cnt_nxt = sb_cnt_r;
		sb_half_nxt = sb_half_r;
		if (wr_sa) begin
			sa_cnt_nxt = bus.wdata;
			sa_half_nxt = 1'b0;
		end else if (tick_a) begin
			if (sa_cnt_r == ppac_pkg::SCALE_ONE) begin
				sa_cnt_nxt = scale_a_value_r;
				sa_half_nxt = !sa_half_r;
			end else begin
				sa_cnt_nxt = sa_cnt_r - 1'b1; // zero wraps to 255, giving 256
			end
		end
		if (wr_sb) begin
			sb_cnt_nxt = bus.wdata;
			sb_half_nxt = 1'b0;
		end else if (tick_b) begin
			if (sb_cnt_r == ppac_pkg::SCALE_ONE) begin
				sb_cnt_nxt = scale_b_value_r;
				sb_half_nxt = !sb_half_r;
			end else begin
				sb_cnt_nxt = sb_cnt_r - 1'b1;
			end
		end
	end
	assign scaled_clock_a = !wr_sa && tick_a && sa_cnt_r == ppac_pkg::SCALE_ONE && sa_half_r;
	assign scaled_clock_b = !wr_sb && tick_b && sb_cnt_r == ppac_pkg::SCALE_ONE && sb_half_r;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pre_cnt_r <= '0;
			sa_cnt_r <= ppac_pkg::RST_REG;
			sb_cnt_r <= ppac_pkg::RST_REG;
			sa_half_r <= 1'b0;
			sb_half_r <= 1'b0;
		end else if (clk_en) begin
			pre_cnt_r <= pre_cnt_nxt;
			sa_cnt_r <= sa_cnt_nxt;
			sb_cnt_r <= sb_cnt_nxt;
			sa_half_r <= sa_half_nxt;
			sb_half_r <= sb_half_nxt;
		end
	end

	assign ticks = '{clk_a_en: tick_a && clk_en, clk_b_en: tick_b && clk_en,
		scaled_a_en: scaled_clock_a && clk_en, scaled_b_en: scaled_clock_b && clk_en};

	// per-channel clock choice and pin routing
	generate
		for (genvar n = 0; n < ppac_pkg::NUM_CH; n++) begin : g_ch
			localparam bit GRP_B = ((n / 2) % 2) == 1;
			localparam bit EVEN = (n % 2) == 0;
			logic joined;
			logic sel_eff;
			assign joined = join_pair[n/2];
			if (GRP_B) begin : g_b
				assign channel_tick[n] = sel_eff ? ticks.scaled_b_en : ticks.clk_b_en;
			end else begin : g_a
				assign channel_tick[n] = sel_eff ? ticks.scaled_a_en : ticks.clk_a_en;
			end
			if (EVEN) begin : g_even
				// a joined pair counts on the odd channel's clock choice
				assign sel_eff = joined ? channel_clock_select[n+1] : channel_clock_select[n];
				assign center_align_bit[n] = joined ? 1'b0 : center_r[n];
				assign channel_output_pin[n] = joined ? 1'b0 : channel_out_raw[n];
			end else begin : g_odd
				assign sel_eff = channel_clock_select[n];
				assign center_align_bit[n] = center_r[n];
				assign channel_output_pin[n] = channel_out_raw[n];
			end
		end
	endgenerate

	// pin routing and alignment under concatenation
	AST_JOIN_PIN0_OFF: assert property (@(posedge ref_clk) disable iff (rst)
		join_pair[0] |-> !channel_output_pin[0]) else $error("pin 0 driven while pair joined");
	AST_JOIN_PIN2_OFF: assert property (@(posedge ref_clk) disable iff (rst)
		join_pair[1] |-> !channel_output_pin[2]) else $error("pin 2 driven while pair joined");
	AST_JOIN_PIN4_OFF: assert property (@(posedge ref_clk) disable iff (rst)
		join_pair[2] |-> !channel_output_pin[4]) else $error("pin 4 driven while pair joined");
	AST_JOIN_PIN7_PASS: assert property (@(posedge ref_clk) disable iff (rst)
		channel_output_pin[7] == channel_out_raw[7] && (!join_pair[3] || !channel_output_pin[6]))
		else $error("pin 6/7 routing wrong");
	AST_ODD_PIN1_PASS: assert property (@(posedge ref_clk) disable iff (rst)
		channel_output_pin[1] == channel_out_raw[1])
		else $error("pin 1 not driven by its channel");
	AST_ODD_PIN3_PASS: assert property (@(posedge ref_clk) disable iff (rst)
		channel_output_pin[3] == channel_out_raw[3])
		else $error("pin 3 not driven by its channel");
	AST_ODD_PIN5_PASS: assert property (@(posedge ref_clk) disable iff (rst)
		channel_output_pin[5] == channel_out_raw[5])
		else $error("pin 5 not driven by its channel");
	AST_EVEN_ALIGN_IGNORED: assert property (@(posedge ref_clk) disable iff (rst)
		join_pair[0] |-> !center_align_bit[0]) else $error("even alignment not ignored");
	AST_EVEN_ALIGN2_IGNORED: assert property (@(posedge ref_clk) disable iff (rst)
		join_pair[1] |-> !center_align_bit[2])
		else $error("channel 2 alignment not ignored");
	AST_EVEN_ALIGN4_IGNORED: assert property (@(posedge ref_clk) disable iff (rst)
		join_pair[2] |-> !center_align_bit[4])
		else $error("channel 4 alignment not ignored");
	AST_EVEN_ALIGN6_IGNORED: assert property (@(posedge ref_clk) disable iff (rst)
		join_pair[3] |-> !center_align_bit[6])
		else $error("channel 6 alignment not ignored");
	AST_ALIGN_FOLLOWS_REG: assert property (@(posedge ref_clk) disable iff (rst)
		bus.wr && clk_en && bus.addr == ppac_pkg::OFS_CENTER |=> center_align_bit[1] == $past(bus.wdata[1]))
		else $error("alignment bit not updated");

	// clock choice per channel
	AST_JOIN_TICK0_ODD: assert property (@(posedge ref_clk) disable iff (rst)
		join_pair[0] |-> channel_tick[0] == channel_tick[1])
		else $error("channel 0 clock not following channel 1");
	AST_JOIN_TICK2_ODD: assert property (@(posedge ref_clk) disable iff (rst)
		join_pair[1] |-> channel_tick[2] == channel_tick[3])
		else $error("channel 2 clock not following channel 3");
	AST_JOIN_TICK4_ODD: assert property (@(posedge ref_clk) disable iff (rst)
		join_pair[2] |-> channel_tick[4] == channel_tick[5])
		else $error("channel 4 clock not following channel 5");
	AST_JOIN_TICK6_ODD: assert property (@(posedge ref_clk) disable iff (rst)
		join_pair[3] |-> channel_tick[6] == channel_tick[7])
		else $error("channel 6 clock not following channel 7");
	AST_SEL_UNSCALED_A: assert property (@(posedge ref_clk) disable iff (rst)
		!channel_clock_select[1] |-> channel_tick[1] == ticks.clk_a_en)
		else $error("channel 1 not on clock a");
	AST_SEL_SCALED_A: assert property (@(posedge ref_clk) disable iff (rst)
		channel_clock_select[5] |-> channel_tick[5] == ticks.scaled_a_en)
		else $error("channel 5 not on scaled clock a");
	AST_SEL_SCALED_B: assert property (@(posedge ref_clk) disable iff (rst)
		channel_clock_select[3] |-> channel_tick[3] == ticks.scaled_b_en)
		else $error("channel 3 not on scaled clock b");
	AST_SEL_UNSCALED_B: assert property (@(posedge ref_clk) disable iff (rst)
		!join_pair[3] && !channel_clock_select[6] |-> channel_tick[6] == ticks.clk_b_en)
		else $error("channel 6 not on clock b");

	// prescaler gating and rates
	AST_DOZE_STOP: assert property (@(posedge ref_clk) disable iff (rst)
		control_r[ppac_pkg::CTL_DOZE] && doze_mode |-> !tick_a && !tick_b) else $error("tick during doze");
	AST_DEBUG_STOP: assert property (@(posedge ref_clk) disable iff (rst)
		control_r[ppac_pkg::CTL_DEBUG] && breakpoint_signal && clk_en |=> $stable(pre_cnt_r))
		else $error("prescaler ran in debug");
	AST_NO_STOP_RUNS: assert property (@(posedge ref_clk) disable iff (rst)
		!control_r[ppac_pkg::CTL_DOZE] && !control_r[ppac_pkg::CTL_DEBUG]
		&& clock_b_prescale_sel == 3'h0 |-> tick_b)
		else $error("prescaler stopped with both stop bits clear");
	AST_DIV1_EVERY: assert property (@(posedge ref_clk) disable iff (rst)
		clock_a_prescale_sel == 3'h0 && pre_run |-> tick_a) else $error("div 1 missing tick");
	AST_DIV2_SPACING: assert property (@(posedge ref_clk) disable iff (rst)
		clock_b_prescale_sel == 3'h1 && tick_b && clk_en && pre_run ##1 pre_run && clk_en
		&& $stable(prescale_r) |-> !tick_b) else $error("div 2 ticked twice in a row");
	AST_DIV4_PHASE: assert property (@(posedge ref_clk) disable iff (rst)
		clock_b_prescale_sel == 3'h2 && tick_b |-> pre_cnt_r[1:0] == 2'h3)
		else $error("div 4 tick off phase");
	AST_DIV128_PHASE: assert property (@(posedge ref_clk) disable iff (rst)
		clock_a_prescale_sel == 3'h7 && tick_a |-> pre_cnt_r == 7'h7f)
		else $error("div 128 tick off phase");
	AST_RESERVED_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
		(prescale_r & ~ppac_pkg::PRESCALE_MASK) == 8'h00 && (control_r & ~ppac_pkg::CONTROL_MASK) == 8'h00)
		else $error("reserved bits set");

	// scaled clocks
	AST_SCALE_RELOAD: assert property (@(posedge ref_clk) disable iff (rst)
		wr_sa && clk_en |=> sa_cnt_r == $past(bus.wdata) && !sa_half_r) else $error("scale reload missed");
	AST_SCALE_WRITE_QUIET: assert property (@(posedge ref_clk) disable iff (rst)
		wr_sa |-> !scaled_clock_a)
		else $error("scaled pulse in reload cycle");
	AST_SCALED_A_ON_TICK: assert property (@(posedge ref_clk) disable iff (rst)
		ticks.scaled_a_en |-> ticks.clk_a_en)
		else $error("scaled a pulse without clock a tick");
	AST_SCALED_B_ON_TICK: assert property (@(posedge ref_clk) disable iff (rst)
		ticks.scaled_b_en |-> ticks.clk_b_en)
		else $error("scaled b pulse without clock b tick");
endmodule : ppac_ctrl

// *** verification/ppac_ctrl_test.sv ***
// Purpose: self-checking bench for the pwm prescale, alignment and concatenation control
// Assumes: 50 MHz ref_clk, reset held 12 cycles, bus master never waits
// Notes: tick rates are checked by counting pulses over windows that hold whole periods
`timescale 1ns/100ps
module ppac_ctrl_test;
	logic ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, doze_mode = 1'b0, breakpoint_signal = 1'b0, rd_d = 1'b0;
	ppac_pkg::ppac_bus_s bus = '0;
	logic [7:0] channel_clock_select = 8'h00, channel_out_raw = 8'h00;
	logic [7:0] rdata, center_align_bit, channel_output_pin, channel_tick, e, cc, rw, m;
	logic [3:0] join_pair;
	ppac_pkg::ppac_tick_s ticks;
	logic [7:0] exp_q[$];
	integer seed = 32'hb507;
	int n_errors = 0, compares = 0, cnt[12];
	always #10 ref_clk = ~ref_clk;
	ppac_ctrl DUT (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .bus(bus), .rdata(rdata),
		.doze_mode(doze_mode), .breakpoint_signal(breakpoint_signal), .channel_clock_select(channel_clock_select),
		.channel_out_raw(channel_out_raw), .ticks(ticks), .channel_tick(channel_tick),
		.center_align_bit(center_align_bit), .join_pair(join_pair), .channel_output_pin(channel_output_pin));
	task chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : chk
	task results;
		$display("compares %0d, mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : results
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus <= '0;
	endtask : wr
	task rd(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		exp_q.push_back(d);
		@(posedge ref_clk);
		bus <= '0;
	endtask : rd
	task count(input int n);
		cnt = '{default: 0};
		repeat (n) @(negedge ref_clk) begin
			for (int i = 0; i < 8; i++) cnt[i] += int'(channel_tick[i]);
			for (int i = 0; i < 4; i++) cnt[8 + i] += int'(ticks[3 - i]);
		end
	endtask : count
	// read data stands only in the cycle after the strobe
	always @(posedge ref_clk) begin
		rd_d <= bus.rd;
		if (rd_d && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			chk("rdata", 16'(e), 16'(rdata));
		end
	end
	initial begin
		#1000000;
		n_errors++;
		results;
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		rd(ppac_pkg::OFS_CONTROL, 8'h00);
		wr(ppac_pkg::OFS_PRESCALE, 8'h77);
		wr(ppac_pkg::OFS_CONTROL, 8'hfc);
		wr(ppac_pkg::OFS_CENTER, 8'ha5);
		wr(4'hf, 8'h5a);
		rd(ppac_pkg::OFS_PRESCALE, 8'h77);
		rd(ppac_pkg::OFS_CONTROL, 8'hfc);
		rd(ppac_pkg::OFS_CENTER, 8'ha5);
		rd(4'hf, 8'h00);
		wr(ppac_pkg::OFS_CONTROL, 8'h00);
		$display("register test done");
		for (int s = 0; s < 8; s++) begin
			wr(ppac_pkg::OFS_PRESCALE, {1'b0, 3'(7 - s), 1'b0, 3'(s)});
			count(256);
			chk("clock a ticks", 16'(256 >> s), 16'(cnt[8]));
			chk("clock b ticks", 16'(256 >> (7 - s)), 16'(cnt[9]));
		end
		$display("prescale test done");
		wr(ppac_pkg::OFS_PRESCALE, 8'h00);
		for (int k = 0; k < 16; k++) begin
			wr(ppac_pkg::OFS_CONTROL, {4'h0, 2'(k), 2'b00});
			doze_mode <= k[2];
			breakpoint_signal <= k[3];
			count(16);
			chk("run ticks", ((k[1] && k[2]) || (k[0] && k[3])) ? 16'h0 : 16'h10, 16'(cnt[8]));
		end
		@(posedge ref_clk);
		doze_mode <= 1'b0;
		breakpoint_signal <= 1'b0;
		clk_en <= 1'b0;
		count(8);
		chk("frozen ticks", 16'h0, 16'(cnt[8]));
		@(posedge ref_clk);
		clk_en <= 1'b1;
		$display("stop test done");
		wr(ppac_pkg::OFS_CONTROL, 8'h00);
		wr(ppac_pkg::OFS_PRESCALE, 8'h10);
		wr(ppac_pkg::OFS_SCALE_A, 8'h02);
		wr(ppac_pkg::OFS_SCALE_B, 8'h02);
		for (int r = 0; r < 4; r++) begin
			@(posedge ref_clk);
			channel_clock_select <= 8'($random(seed));
			count(256);
			chk("scaled a ticks", 16'd64, 16'(cnt[10]));
			chk("scaled b ticks", 16'd32, 16'(cnt[11]));
			for (int i = 0; i < 8; i++) chk("channel tick", 16'(i[1] ? (channel_clock_select[i] ? 32 : 128) :
				(channel_clock_select[i] ? 64 : 256)), 16'(cnt[i]));
		end
		wr(ppac_pkg::OFS_SCALE_A, 8'h00);
		count(1024);
		chk("scaled a zero", 16'd2, 16'(cnt[10]));
		$display("scaled clock test done");
		wr(ppac_pkg::OFS_SCALE_A, 8'h02);
		channel_clock_select <= 8'haa;
		for (int r = 0; r < 16; r++) begin
			@(posedge ref_clk);
			cc = 8'($random(seed));
			rw = 8'($random(seed));
			e = 8'(r);
			m = ~{1'b0, e[3], 1'b0, e[2], 1'b0, e[1], 1'b0, e[0]};
			// channels idle while alignment and join bits change
			channel_out_raw <= 8'h00;
			wr(ppac_pkg::OFS_CENTER, cc);
			wr(ppac_pkg::OFS_CONTROL, {e[3:0], 4'h0});
			channel_out_raw <= rw;
			@(negedge ref_clk);
			chk("join flags", 16'(e[3:0]), 16'(join_pair));
			chk("alignment", 16'(cc & m), 16'(center_align_bit));
			chk("pins", 16'(rw & m), 16'(channel_output_pin));
			count(16);
			for (int i = 0; i < 8; i++) chk("joined tick", 16'(i[1] ? ((i[0] || e[i / 2]) ? 2 : 8) :
				((i[0] || e[i / 2]) ? 4 : 16)), 16'(cnt[i]));
		end
		$display("join test done");
		results;
	end
endmodule : ppac_ctrl_test
